// *** rtl/fpm_ctrl.sv ***
`default_nettype none
module fpm_ctrl #(
  parameter int NSEC = fpm_pkg::NUM_SEC,
  parameter int MIN_INIT = fpm_pkg::MIN_INIT_CYC,
  parameter int SLEEP_N = fpm_pkg::SLEEP_CYC,
  parameter int POLL_N = fpm_pkg::POLL_CYC
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic pin_rst_n,
  input wire logic vpp_ok,
  input wire logic [fpm_pkg::ADDR_W-1:0] addr,
  input wire logic [fpm_pkg::DQ_W-1:0] dq_in,
  output logic [fpm_pkg::DQ_W-1:0] dq_out,
  output logic dq_oe,
  input wire logic [fpm_pkg::DQ_W-1:0] array_rdata,
  input wire logic op_busy,
  output logic op_start,
  output logic op_erase,
  output logic [fpm_pkg::SEC_W-1:0] op_sector,
  output logic [fpm_pkg::ADDR_W-1:0] op_addr,
  output logic [fpm_pkg::DQ_W-1:0] op_data,
  output logic op_abort,
  input wire logic [fpm_pkg::REG_AW-1:0] reg_addr,
  input wire logic [fpm_pkg::REG_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [fpm_pkg::REG_DW-1:0] reg_rdata
);
  import fpm_pkg::*;
  localparam int PC_W = $clog2(MIN_INIT + 1);
  localparam int SC_W = $clog2(SLEEP_N + 1);
  localparam int QC_W = $clog2(POLL_N + 1);
  localparam logic [PC_W-1:0] PRST_MAX = PC_W'(MIN_INIT);
  localparam logic [SC_W-1:0] SLEEP_MAX = SC_W'(SLEEP_N);
  localparam logic [QC_W-1:0] POLL_MAX = QC_W'(POLL_N);
  localparam int POLL_A = POLL_N + 2;

  // ----------------------------------------------------------------
  // Write qualification and captured write cycle
  // ----------------------------------------------------------------
  logic wr_fire;
  logic [ADDR_W-1:0] wa_r, wa_nxt;
  logic [DQ_W-1:0] wd_r, wd_nxt;

  fpm_wr_qual #(.MIN_CYC(MIN_WE_CYC)) u_wr_qual (
    .core_clk(core_clk),
    .nrst(nrst),
    .ce_n(ce_n),
    .we_n(we_n),
    .oe_n(oe_n),
    .pin_rst_n(pin_rst_n),
    .wr_fire(wr_fire)
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  fpm_seq_e seq_r, seq_nxt;
  fpm_mode_e mode_r, mode_nxt;
  logic [PC_W-1:0] prst_r, prst_nxt;
  logic [SC_W-1:0] stab_r, stab_nxt;
  logic [QC_W-1:0] poll_r, poll_nxt;
  logic [ADDR_W-1:0] addr_d_r, addr_d_nxt;
  logic [BANK_W-1:0] id_bank_r, id_bank_nxt;
  logic [NSEC-1:0] guard_r, guard_nxt;
  logic lock_r, lock_nxt;
  logic [SEC_W-1:0] sel_r, sel_nxt;
  logic start_r, start_nxt, erase_r, erase_nxt, abort_r, abort_nxt;
  logic [SEC_W-1:0] osec_r, osec_nxt;
  logic [ADDR_W-1:0] oaddr_r, oaddr_nxt;
  logic [DQ_W-1:0] odata_r, odata_nxt;
  logic [DQ_W-1:0] dq_r, dq_nxt;
  logic [REG_DW-1:0] rd_r, rd_nxt;

  logic hw_rst, sleep, g_wr, g_val, lock_pgm, req, req_erase, blocked;
  logic [SEC_W-1:0] wsec, rsec;
  logic [CMD_W-1:0] code;
  logic [DQ_W-1:0] rd_val;

  assign hw_rst = (prst_r == PRST_MAX);
  assign sleep = (stab_r == SLEEP_MAX);
  assign wsec = wa_r[ADDR_W-1 -: SEC_W];
  assign rsec = addr[ADDR_W-1 -: SEC_W];
  assign code = wd_r[CMD_W-1:0];

  // ----------------------------------------------------------------
  // Command sequencer
  // ----------------------------------------------------------------
  always_comb begin
    wa_nxt = (!we_n && !ce_n) ? addr : wa_r;
    wd_nxt = (!we_n && !ce_n) ? dq_in : wd_r;
    prst_nxt = pin_rst_n ? '0 : ((prst_r < PRST_MAX) ? prst_r + 1'b1 : prst_r);
    seq_nxt = seq_r;
    mode_nxt = mode_r;
    id_bank_nxt = id_bank_r;
    lock_nxt = lock_r;
    g_wr = 1'b0;
    g_val = GUARD_OPEN;
    lock_pgm = 1'b0;
    req = 1'b0;
    req_erase = 1'b0;
    poll_nxt = (poll_r != '0) ? poll_r - 1'b1 : poll_r;
    if (mode_r == MD_POLL && poll_r == '0) begin
      mode_nxt = MD_ARRAY;
    end
    if (hw_rst) begin
      seq_nxt = SQ_IDLE;
      mode_nxt = MD_ARRAY;
    end else if (wr_fire) begin
      if (code == CMD_RESET && seq_r != SQ_PDATA) begin
        seq_nxt = SQ_IDLE;
        mode_nxt = MD_ARRAY;
      end else begin
        unique case (seq_r)
          SQ_IDLE: begin
            seq_nxt = (wa_r[UNLK_AW-1:0] == UNLK1_ADDR && code == UNLK1_DATA) ? SQ_UNLK1 : SQ_IDLE;
          end
          SQ_UNLK1: begin
            seq_nxt = (wa_r[UNLK_AW-1:0] == UNLK2_ADDR && code == UNLK2_DATA) ? SQ_UNLK2 : SQ_IDLE;
          end
          SQ_UNLK2: begin
            seq_nxt = SQ_IDLE;
            if (code == CMD_IDENT) begin
              mode_nxt = MD_IDENT;
              id_bank_nxt = wa_r[ADDR_W-1 -: BANK_W];
            end else if (code == CMD_PROG) begin
              seq_nxt = SQ_PDATA;
            end else if (code == CMD_ERASE) begin
              req = 1'b1;
              req_erase = 1'b1;
            end else if (code == CMD_GSET || code == CMD_GCLR) begin
              g_wr = !(op_busy && osec_r == wsec);
              g_val = (code == CMD_GSET) ? GUARD_SHUT : GUARD_OPEN;
            end else if (code == CMD_GSTAT) begin
              mode_nxt = MD_GSTAT;
            end else if (code == CMD_LOCK_RD) begin
              mode_nxt = MD_LOCK;
            end else if (code == CMD_LOCK_PGM) begin
              lock_nxt = 1'b1;
              lock_pgm = 1'b1;
            end
          end
          SQ_PDATA: begin
            seq_nxt = SQ_IDLE;
            req = 1'b1;
          end
        endcase
      end
    end
    // Protection: a guarded sector or a low protection pin turns the request into polling only
    blocked = (guard_r[wsec] == GUARD_SHUT) || !vpp_ok || op_busy;
    start_nxt = req && !blocked;
    erase_nxt = start_nxt ? req_erase : erase_r;
    osec_nxt = start_nxt ? wsec : osec_r;
    oaddr_nxt = start_nxt ? wa_r : oaddr_r;
    odata_nxt = start_nxt ? wd_r : odata_r;
    if (req && blocked) begin
      mode_nxt = MD_POLL;
      poll_nxt = POLL_MAX;
    end
    // Deselect does not touch the engine; only the reset pin aborts
    abort_nxt = hw_rst;
  end

  // Guard bits: reset and lock programming both restore the open default
  for (genvar i = 0; i < NSEC; i++) begin : g_guard
    assign guard_nxt[i] = (hw_rst || lock_pgm) ? GUARD_OPEN :
      ((g_wr && wsec == SEC_W'(i)) ? g_val : guard_r[i]);
  end

  // ----------------------------------------------------------------
  // Read path and automatic sleep
  // ----------------------------------------------------------------
  always_comb begin
    addr_d_nxt = addr;
    stab_nxt = (addr != addr_d_r) ? '0 : ((stab_r < SLEEP_MAX) ? stab_r + 1'b1 : stab_r);
    rd_val = array_rdata;
    unique case (mode_r)
      MD_ARRAY: rd_val = array_rdata;
      MD_IDENT: begin
        if (addr[ADDR_W-1 -: BANK_W] == id_bank_r) begin
          unique case (addr[ID_OFS_W-1:0])
            ID_MFR: rd_val = MFR_CODE;
            ID_DEV: rd_val = DEV_CODE;
            ID_PROT: rd_val = {{(DQ_W-1){1'b0}}, guard_r[rsec] == GUARD_SHUT};
            default: rd_val = '0;
          endcase
        end
      end
      MD_GSTAT: rd_val = {{(DQ_W-1){1'b0}}, guard_r[rsec]};
      MD_LOCK: rd_val = {{(DQ_W-1){1'b0}}, lock_r};
      MD_POLL: rd_val = POLL_WORD ^ ({{(DQ_W-1){1'b0}}, poll_r[0]} << POLL_TOG_BIT);
      default: rd_val = array_rdata;
    endcase
    // Sleeping holds the last word so a slow host still sees valid data
    dq_nxt = sleep ? dq_r : rd_val;
    dq_oe = !ce_n && !oe_n && pin_rst_n && !hw_rst;
  end

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  always_comb begin
    sel_nxt = (reg_wr && reg_addr == REG_CTRL) ? reg_wdata[SEC_W-1:0] : sel_r;
    rd_nxt = '0;
    if (reg_rd) begin
      unique case (reg_addr)
        REG_LOCK: rd_nxt[0] = lock_r;
        REG_CTRL: rd_nxt[SEC_W-1:0] = sel_r;
        REG_STAT: begin
          rd_nxt[ST_GUARD] = guard_r[sel_r];
          rd_nxt[ST_MODE +: 3] = mode_r;
          rd_nxt[ST_BUSY] = op_busy;
          rd_nxt[ST_SLEEP] = sleep;
          rd_nxt[ST_STBY] = ce_n && pin_rst_n && !op_busy;
          rd_nxt[ST_RST] = hw_rst;
          rd_nxt[ST_LOCK] = lock_r;
        end
        default: rd_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wa_r <= '0;
      wd_r <= '0;
      prst_r <= '0;
      seq_r <= SQ_IDLE;
      mode_r <= MD_ARRAY;
      id_bank_r <= '0;
      lock_r <= 1'b0;
      guard_r <= '1;
      poll_r <= '0;
      start_r <= 1'b0;
      erase_r <= 1'b0;
      osec_r <= '0;
      oaddr_r <= '0;
      odata_r <= '0;
      abort_r <= 1'b0;
      addr_d_r <= '0;
      stab_r <= '0;
      dq_r <= '0;
      sel_r <= '0;
      rd_r <= '0;
    end else begin
      wa_r <= wa_nxt;
      wd_r <= wd_nxt;
      prst_r <= prst_nxt;
      seq_r <= seq_nxt;
      mode_r <= mode_nxt;
      id_bank_r <= id_bank_nxt;
      lock_r <= lock_nxt;
      guard_r <= guard_nxt;
      poll_r <= poll_nxt;
      start_r <= start_nxt;
      erase_r <= erase_nxt;
      osec_r <= osec_nxt;
      oaddr_r <= oaddr_nxt;
      odata_r <= odata_nxt;
      abort_r <= abort_nxt;
      addr_d_r <= addr_d_nxt;
      stab_r <= stab_nxt;
      dq_r <= dq_nxt;
      sel_r <= sel_nxt;
      rd_r <= rd_nxt;
    end
  end

  assign dq_out = dq_r;
  assign op_start = start_r;
  assign op_erase = erase_r;
  assign op_sector = osec_r;
  assign op_addr = oaddr_r;
  assign op_data = odata_r;
  assign op_abort = abort_r;
  assign reg_rdata = rd_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  guard_reset_a: assert property (@(posedge core_clk) disable iff (!nrst)
    hw_rst |=> &guard_r)
    else $error("guard bits not open after reset pulse");
  lock_guard_a: assert property (@(posedge core_clk) disable iff (!nrst)
    $rose(lock_r) |-> &guard_r)
    else $error("guard bits kept after lock programming");
  prot_block_a: assert property (@(posedge core_clk) disable iff (!nrst)
    op_start |-> guard_r[op_sector] == GUARD_OPEN && $past(vpp_ok))
    else $error("operation started on a locked sector");
  poll_return_a: assert property (@(posedge core_clk) disable iff (!nrst)
    $rose(mode_r == MD_POLL) |-> ##[1:POLL_A] (mode_r == MD_ARRAY))
    else $error("polling did not return to array read");
  ident_bank_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (mode_r == MD_IDENT && addr[ADDR_W-1 -: BANK_W] != id_bank_r && !sleep) |=> dq_out == $past(array_rdata))
    else $error("other bank did not read array data");
  float_out_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (oe_n || ce_n) ##1 (oe_n || ce_n) |-> !dq_oe && !$past(dq_oe))
    else $error("outputs driven while disabled");
  init_pulse_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (!pin_rst_n) [*8] |=> hw_rst && !wr_fire ##1 op_abort && mode_r == MD_ARRAY)
    else $error("long reset pulse did not abort");
  sleep_hold_a: assert property (@(posedge core_clk) disable iff (!nrst)
    sleep && $stable(addr) |=> $stable(dq_out))
    else $error("sleep did not hold output data");
endmodule : fpm_ctrl
`default_nettype wire

// *** rtl/fpm_pkg.sv ***
`default_nettype none
package fpm_pkg;
  // ----------------------------------------------------------------
  // Clock and widths
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 40;
  localparam int ADDR_W = 22;
  localparam int DQ_W = 16;
  localparam int SEC_W = 7;
  localparam int NUM_SEC = 128;
  localparam int BANK_W = 3;
  localparam int REG_AW = 4;
  localparam int REG_DW = 32;
  localparam int UNLK_AW = 12;
  localparam int CMD_W = 8;
  localparam int ID_OFS_W = 2;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int MIN_WRITE_PULSE_NS = 40;
  localparam int MIN_INIT_PULSE_NS = 200;
  localparam int ACCESS_TIME_NS = 100;
  localparam int SLEEP_EXTRA_NS = 20;
  localparam int POLL_NS = 500;
  localparam int MIN_WE_CYC = (MIN_WRITE_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int MIN_INIT_CYC = (MIN_INIT_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int SLEEP_CYC = ((ACCESS_TIME_NS + SLEEP_EXTRA_NS) * CLK_MHZ + 999) / 1000;
  localparam int POLL_CYC = (POLL_NS * CLK_MHZ + 999) / 1000;

  // ----------------------------------------------------------------
  // Command set
  // ----------------------------------------------------------------
  localparam logic [UNLK_AW-1:0] UNLK1_ADDR = 12'h555;
  localparam logic [UNLK_AW-1:0] UNLK2_ADDR = 12'h2aa;
  localparam logic [CMD_W-1:0] UNLK1_DATA = 8'haa;
  localparam logic [CMD_W-1:0] UNLK2_DATA = 8'h55;
  localparam logic [CMD_W-1:0] CMD_RESET = 8'hf0;
  localparam logic [CMD_W-1:0] CMD_IDENT = 8'h90;
  localparam logic [CMD_W-1:0] CMD_PROG = 8'ha0;
  localparam logic [CMD_W-1:0] CMD_ERASE = 8'h30;
  localparam logic [CMD_W-1:0] CMD_GSET = 8'h48;
  localparam logic [CMD_W-1:0] CMD_GCLR = 8'h49;
  localparam logic [CMD_W-1:0] CMD_GSTAT = 8'h58;
  localparam logic [CMD_W-1:0] CMD_LOCK_RD = 8'h40;
  localparam logic [CMD_W-1:0] CMD_LOCK_PGM = 8'h41;

  // ----------------------------------------------------------------
  // Identification data (codes are arbitrary)
  // ----------------------------------------------------------------
  localparam logic [ID_OFS_W-1:0] ID_MFR = 2'h0;
  localparam logic [ID_OFS_W-1:0] ID_DEV = 2'h1;
  localparam logic [ID_OFS_W-1:0] ID_PROT = 2'h2;
  localparam logic [DQ_W-1:0] MFR_CODE = 16'h00a5;
  localparam logic [DQ_W-1:0] DEV_CODE = 16'h005a;
  localparam logic [DQ_W-1:0] POLL_WORD = 16'h0080;
  localparam int POLL_TOG_BIT = 6;
  localparam logic GUARD_OPEN = 1'b1;
  localparam logic GUARD_SHUT = 1'b0;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [REG_AW-1:0] REG_LOCK = 4'h0;
  localparam logic [REG_AW-1:0] REG_CTRL = 4'h4;
  localparam logic [REG_AW-1:0] REG_STAT = 4'h8;
  localparam int ST_GUARD = 0;
  localparam int ST_MODE = 1;
  localparam int ST_BUSY = 4;
  localparam int ST_SLEEP = 5;
  localparam int ST_STBY = 6;
  localparam int ST_RST = 7;
  localparam int ST_LOCK = 8;

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SQ_IDLE = 2'b00,
    SQ_UNLK1 = 2'b01,
    SQ_UNLK2 = 2'b11,
    SQ_PDATA = 2'b10
  } fpm_seq_e;

  typedef enum logic [2:0] {
    MD_ARRAY = 3'b000,
    MD_IDENT = 3'b001,
    MD_GSTAT = 3'b011,
    MD_LOCK = 3'b010,
    MD_POLL = 3'b110
  } fpm_mode_e;
endpackage : fpm_pkg
`default_nettype wire

// *** rtl/fpm_wr_qual.sv ***
`default_nettype none
module fpm_wr_qual #(
  parameter int MIN_CYC = fpm_pkg::MIN_WE_CYC
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic pin_rst_n,
  output logic wr_fire
);
  import fpm_pkg::*;
  localparam int CW = $clog2(MIN_CYC + 1);
  localparam logic [CW-1:0] LEN_MAX = CW'(MIN_CYC);

  logic [CW-1:0] len_r, len_nxt;
  logic ok_r, ok_nxt;
  logic we_d_r, we_d_nxt;
  logic first_r, first_nxt;
  logic pu_blk_r, pu_blk_nxt;
  logic active, rise;

  always_comb begin
    active = !ce_n && !we_n && oe_n && pin_rst_n;
    rise = !we_d_r && we_n;
    we_d_nxt = we_n;
    first_nxt = 1'b0;
    len_nxt = len_r;
    ok_nxt = ok_r;
    if (we_n) begin
      len_nxt = '0;
      ok_nxt = 1'b1;
    end else if (!active) begin
      ok_nxt = 1'b0;
    end else if (len_r < LEN_MAX) begin
      len_nxt = len_r + 1'b1;
    end
    // Strap-like check is taken at the first edge after release, never in reset
    if (first_r) begin
      pu_blk_nxt = !we_n && !ce_n && !pin_rst_n && oe_n;
    end else begin
      pu_blk_nxt = pu_blk_r && !rise;
    end
    wr_fire = rise && ok_r && (len_r >= LEN_MAX) && !pu_blk_r;
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      len_r <= '0;
      ok_r <= 1'b1;
      we_d_r <= 1'b1;
      first_r <= 1'b1;
      pu_blk_r <= 1'b0;
    end else begin
      len_r <= len_nxt;
      ok_r <= ok_nxt;
      we_d_r <= we_d_nxt;
      first_r <= first_nxt;
      pu_blk_r <= pu_blk_nxt;
    end
  end

  short_pulse_a: assert property (@(posedge core_clk) disable iff (!nrst)
    wr_fire |-> !$past(we_n) && !$past(we_n, MIN_CYC))
    else $error("write fired on a short strobe");
  oe_block_a: assert property (@(posedge core_clk) disable iff (!nrst)
    wr_fire |-> $past(oe_n) && !$past(ce_n))
    else $error("write fired with output enable or select wrong");
endmodule : fpm_wr_qual
`default_nettype wire

// *** verification/fpm_host.sv ***
`default_nettype none
module fpm_host (
  input wire logic core_clk,
  output logic ce_n,
  output logic we_n,
  output logic oe_n,
  output logic [fpm_pkg::ADDR_W-1:0] addr,
  output logic [fpm_pkg::DQ_W-1:0] dq_in,
  input wire logic [fpm_pkg::DQ_W-1:0] dq_out,
  input wire logic op_start,
  output logic op_busy,
  output logic [fpm_pkg::DQ_W-1:0] array_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  import fpm_pkg::*;
  int busy_cnt = 0;
  int n_start = 0;

  // ----------------------------------------------------------------
  // Array and engine stand-in
  // ----------------------------------------------------------------
  // Array word differs from any identifier code for the addresses used
  assign array_rdata = ~addr[15:0];
  assign op_busy = (busy_cnt != 0);

  initial begin
    ce_n = 1'b1;
    we_n = 1'b1;
    oe_n = 1'b1;
    addr = '0;
    dq_in = '0;
  end

  always @(posedge core_clk) begin
    if (op_start === 1'b1) begin
      n_start++;
      busy_cnt <= 40;
    end else if (busy_cnt != 0) begin
      busy_cnt <= busy_cnt - 1;
    end
  end

  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  // Fault kind: 0 clean, 1 output enable held low, 2 strobe pulse too short
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DQ_W-1:0] d, input int bad);
    @(posedge core_clk);
    ce_n <= 1'b0;
    we_n <= 1'b0;
    oe_n <= (bad == 1) ? 1'b0 : 1'b1;
    addr <= a;
    dq_in <= d;
    repeat ((bad == 2) ? 1 : 3) @(posedge core_clk);
    we_n <= 1'b1;
    @(posedge core_clk);
    ce_n <= 1'b1;
    oe_n <= 1'b1;
    dq_in <= ~d;
  endtask : wr

  task automatic cmd(input logic [ADDR_W-1:0] a, input logic [CMD_W-1:0] c, input int bad);
    wr({10'h000, UNLK1_ADDR}, {8'h00, UNLK1_DATA}, bad);
    wr({10'h000, UNLK2_ADDR}, {8'h00, UNLK2_DATA}, bad);
    wr(a, {8'h00, c}, bad);
  endtask : cmd

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DQ_W-1:0] d);
    @(posedge core_clk);
    ce_n <= 1'b0;
    oe_n <= 1'b0;
    addr <= a;
    repeat (2) @(posedge core_clk);
    #1 d = dq_out;
  endtask : rd

  task automatic pins(input logic ce, input logic oe);
    @(posedge core_clk);
    ce_n <= ce;
    oe_n <= oe;
    @(posedge core_clk);
    #1;
  endtask : pins
endmodule : fpm_host
`default_nettype wire

// *** verification/tb.sv ***
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import fpm_pkg::*;
  logic core_clk, nrst, pin_rst_n, vpp_ok, ce_n, we_n, oe_n, dq_oe, op_busy, op_start, op_erase, op_abort;
  logic reg_wr, reg_rd;
  logic [ADDR_W-1:0] addr, op_addr;
  logic [DQ_W-1:0] dq_in, dq_out, array_rdata, op_data;
  logic [SEC_W-1:0] op_sector;
  logic [REG_AW-1:0] reg_addr;
  logic [REG_DW-1:0] reg_wdata, reg_rdata;
  int n_mismatch = 0;
  int n_tests = 0;
  localparam logic [ADDR_W-1:0] SEC5 = 22'h028555;

  fpm_ctrl dut (.core_clk(core_clk), .nrst(nrst), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n),
    .pin_rst_n(pin_rst_n), .vpp_ok(vpp_ok), .addr(addr), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
    .array_rdata(array_rdata), .op_busy(op_busy), .op_start(op_start), .op_erase(op_erase),
    .op_sector(op_sector), .op_addr(op_addr), .op_data(op_data), .op_abort(op_abort),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  fpm_host host (.core_clk(core_clk), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .addr(addr), .dq_in(dq_in),
    .dq_out(dq_out), .op_start(op_start), .op_busy(op_busy), .array_rdata(array_rdata));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // ----------------------------------------------------------------
  // Register port and run control
  // ----------------------------------------------------------------
  task automatic rg_wr(input logic [REG_AW-1:0] a, input logic [REG_DW-1:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : rg_wr

  task automatic rg_rd(input logic [REG_AW-1:0] a, output logic [REG_DW-1:0] d);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rg_rd

  task automatic st(input logic [SEC_W-1:0] s, output logic [REG_DW-1:0] r);
    rg_wr(REG_CTRL, {25'h0, s});
    rg_rd(REG_STAT, r);
  endtask : st

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run

  // Whole sequence needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    complete_run();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    logic [REG_DW-1:0] r;
    logic [DQ_W-1:0] d;
    int n0;
    nrst = 1'b0;
    pin_rst_n = 1'b0;
    vpp_ok = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    repeat (10) @(posedge core_clk);
    nrst <= 1'b1;
    pin_rst_n <= 1'b1;
    // Address has not moved since reset, so sleep must be reached before the status read
    repeat (SLEEP_CYC) @(posedge core_clk);
    st(7'h05, r);
    `CHK(r[ST_GUARD], GUARD_OPEN)
    `CHK(r[3:1], MD_ARRAY)
    `CHK(r[ST_SLEEP], 1'b1)
    rg_rd(REG_LOCK, r);
    `CHK(r, 32'h0)
    rg_rd(4'hc, r);
    `CHK(r, 32'h0)
    $display("test reset done");

    host.cmd(22'h000555, CMD_IDENT, 0);
    host.rd(22'h000000, d);
    `CHK(d, MFR_CODE)
    host.rd(22'h000001, d);
    `CHK(d, DEV_CODE)
    host.rd(22'h028ab6, d);
    `CHK(d, 16'h0000)
    host.rd(22'h080004, d);
    `CHK(d, 16'hfffb)
    st(7'h00, r);
    `CHK(r[3:1], MD_IDENT)
    host.wr(22'h000000, {8'h00, CMD_RESET}, 0);
    st(7'h00, r);
    `CHK(r[3:1], MD_ARRAY)
    $display("test ident done");

    for (int k = 0; k < 2; k++) begin
      host.cmd(SEC5, CMD_GSET, 0);
      st(7'h05, r);
      `CHK(r[ST_GUARD], GUARD_SHUT)
    end
    host.cmd(SEC5, CMD_GSTAT, 0);
    host.rd(22'h028000, d);
    `CHK(d[0], GUARD_SHUT)
    host.cmd(22'h000555, CMD_IDENT, 0);
    host.rd(22'h028f3e, d);
    `CHK(d, 16'h0001)
    host.wr(22'h000000, {8'h00, CMD_RESET}, 0);
    n0 = host.n_start;
    host.cmd(SEC5, CMD_ERASE, 0);
    st(7'h05, r);
    `CHK(r[3:1], MD_POLL)
    `CHK(host.n_start, n0)
    repeat (POLL_CYC + 10) @(posedge core_clk);
    st(7'h05, r);
    `CHK(r[3:1], MD_ARRAY)
    host.cmd(SEC5, CMD_GCLR, 0);
    st(7'h05, r);
    `CHK(r[ST_GUARD], GUARD_OPEN)
    $display("test guard done");

    vpp_ok <= 1'b0;
    host.cmd(SEC5, CMD_ERASE, 0);
    repeat (POLL_CYC + 10) @(posedge core_clk);
    `CHK(host.n_start, n0)
    vpp_ok <= 1'b1;
    host.cmd(SEC5, CMD_ERASE, 0);
    // Start pulse is launched at the fire edge; look one cycle later
    @(posedge core_clk);
    #1;
    `CHK(host.n_start, n0 + 1)
    `CHK(op_erase, 1'b1)
    `CHK(op_sector, 7'h05)
    `CHK(op_abort, 1'b0)
    host.cmd(SEC5, CMD_GSET, 0);
    st(7'h05, r);
    `CHK(r[ST_GUARD], GUARD_OPEN)
    $display("test erase done");

    // Engine must be idle, or the busy refusal would mask a broken write qualifier
    repeat (40) @(posedge core_clk);
    for (int b = 1; b <= 2; b++) begin
      host.cmd(SEC5, CMD_GSET, b);
      st(7'h05, r);
      `CHK(r[ST_GUARD], GUARD_OPEN)
    end
    host.pins(1'b0, 1'b1);
    `CHK(dq_oe, 1'b0)
    host.pins(1'b1, 1'b0);
    `CHK(dq_oe, 1'b0)
    host.pins(1'b0, 1'b0);
    `CHK(dq_oe, 1'b1)
    $display("test inhibit done");

    host.cmd(SEC5, CMD_GSET, 0);
    host.cmd(22'h000555, CMD_IDENT, 0);
    host.pins(1'b0, 1'b0);
    @(posedge core_clk);
    pin_rst_n <= 1'b0;
    repeat (MIN_INIT_CYC + 3) @(posedge core_clk);
    #1;
    `CHK(op_abort, 1'b1)
    `CHK(dq_oe, 1'b0)
    @(posedge core_clk);
    pin_rst_n <= 1'b1;
    st(7'h05, r);
    `CHK(r[ST_GUARD], GUARD_OPEN)
    `CHK(r[3:1], MD_ARRAY)
    $display("test pin reset done");

    host.cmd(SEC5, CMD_GSET, 0);
    host.cmd(22'h000555, CMD_LOCK_PGM, 0);
    st(7'h05, r);
    `CHK(r[ST_GUARD], GUARD_OPEN)
    rg_wr(REG_LOCK, 32'h0);
    rg_rd(REG_LOCK, r);
    `CHK(r, 32'h1)
    host.cmd(22'h000555, CMD_LOCK_RD, 0);
    host.rd(22'h000000, d);
    `CHK(d[0], 1'b1)
    $display("test lock done");

    // Power-up with strobe, select and pin low: the first strobe edge must be dropped
    host.cmd(SEC5, CMD_GSET, 0);
    @(posedge core_clk);
    nrst <= 1'b0;
    pin_rst_n <= 1'b0;
    host.ce_n <= 1'b0;
    host.oe_n <= 1'b1;
    host.we_n <= 1'b0;
    host.addr <= {10'h000, UNLK1_ADDR};
    host.dq_in <= {8'h00, UNLK1_DATA};
    repeat (10) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge core_clk);
    pin_rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    host.we_n <= 1'b1;
    host.wr({10'h000, UNLK2_ADDR}, {8'h00, UNLK2_DATA}, 0);
    host.wr(22'h000555, {8'h00, CMD_IDENT}, 0);
    st(7'h05, r);
    `CHK(r[ST_GUARD], GUARD_OPEN)
    `CHK(r[3:1], MD_ARRAY)
    $display("test power-up done");
    complete_run();
  end
endmodule : tb
`undef CHK
`default_nettype wire
